// *** design/cpu_external_bus_control.v ***
// external bus control: strobes, wait states, bus hand-over, interrupts
// Notes on behaviour
// [RULE1] io_request_n low on any I/O space access; strobes give direction.
// [RULE2] mem_request_n low during memory access; strobes qualify the kind.
// [RULE3] during grant, address and request lines are inputs, not driven.
// [RULE4] read_strobe_n low when reading; floated while bus granted.
// [RULE5] store_strobe_n low when writing; floated while bus granted.
// [RULE6] opcode_fetch_n low with mem and read strobes; floated when granted.
// [RULE7] wait input low stretches the current read or write.
// [RULE8] reset must be held low at least three clock cycles.
// [RULE9] reset also held until the clock is stable.
// [RULE10] urgent interrupt taken at instruction end regardless of enables.
// [RULE11] urgent interrupt beats every maskable source.
// [RULE12] an external master claims the bus by driving bus_claim_n low.
// [RULE13] on claim, float address, data, control then drive bus_grant_n low.
// [RULE14] stop_state_n low once halt or doze has been executed.
// [RULE15] data bus driven only in write cycles with the cpu as master.
// [RULE16] claim released: drop grant, drive lines again before next cycle.
`timescale 1ns/100ps
`include "ext_bus_map.vh"
module cpu_external_bus_control #(
   parameter AW = `ADDR_WIDTH,
   parameter DW = `DATA_WIDTH,
   parameter NUM_IRQ = 8
) (
   input wire mclk_in, // system clock
   input wire resetn_in, // synchronous reset, active low
   // core request side
   input wire req_valid_in, // core asks for a bus cycle
   input wire [1:0] req_kind_in, // cycle kind
   input wire req_fetch_in, // memory read is an opcode fetch
   input wire [AW-1:0] req_addr_in, // cycle address
   input wire [DW-1:0] req_wdata_in, // write data
   output reg req_ready_out, // request accepted
   output reg done_out, // cycle finished, one-cycle pulse
   output reg [DW-1:0] rdata_out, // read data, valid with done
   input wire instr_end_in, // core at an instruction boundary
   input wire stop_exec_in, // core executes halt or doze
   input wire wake_in, // core leaves halt or doze
   input wire [NUM_IRQ-1:0] irq_pend_in, // maskable requests
   input wire [NUM_IRQ-1:0] irq_enable_in, // maskable enables
   input wire global_ie_in, // global enable
   output reg urgent_take_out, // urgent interrupt taken, pulse
   output reg mask_take_out, // maskable interrupt taken, pulse
   output reg [NUM_IRQ-1:0] mask_sel_out, // chosen maskable source
   output reg granted_out, // bus is with the external master
   // pins
   output reg [AW-1:0] location_bus_out, // address out
   output reg location_bus_oe_out, // address drive enable
   input wire [AW-1:0] location_bus_in, // address seen on pins
   output reg [DW-1:0] data_bus_out, // data out
   output reg data_bus_oe_out, // data drive enable
   input wire [DW-1:0] data_bus_in, // data seen on pins
   output reg io_request_n_out, // i/o request, active low
   output reg mem_request_n_out, // memory request, active low
   input wire io_request_n_in, // i/o request from pins
   input wire mem_request_n_in, // memory request from pins
   output reg read_strobe_n_out, // read strobe, active low
   output reg store_strobe_n_out, // write strobe, active low
   output reg opcode_fetch_n_out, // fetch indicator, active low
   output reg ctrl_oe_out, // enable for requests and strobes
   input wire wait_n_in, // wait request, active low
   input wire urgent_interrupt_n_in, // urgent interrupt, active low
   input wire bus_claim_n_in, // bus claim, active low
   output reg bus_grant_n_out, // bus grant, active low
   output reg stop_state_n_out // halt or doze indicator, active low
);
   localparam ST_IDLE = 3'h0;
   localparam ST_ADDR = 3'h1;
   localparam ST_STROBE = 3'h2;
   localparam ST_FLOAT = 3'h3;
   localparam ST_GRANT = 3'h4;
   localparam ST_RESUME = 3'h5;
   localparam ST_SETTLE = 3'h6;

   // pins are asynchronous to mclk: two stages each
   reg [2:0] sync1_q;
   reg [2:0] sync2_q;
   wire wait_s = sync2_q[0];
   wire urgent_s = sync2_q[1];
   wire claim_s = sync2_q[2];
   reg [2:0] state_q;
   reg [1:0] kind_q;
   reg fetch_q;
   reg urgent_pend_q;
   reg urgent_prev_q;
   wire take_urgent;
   wire take_mask;
   wire [NUM_IRQ-1:0] sel;
   // location_bus_in, io and mem request inputs are observed only by others
   // while granted; the bus controller itself never needs them.

   function is_write;
      input [1:0] k;
      begin
         is_write = (k == `CYC_MEM_WRITE) || (k == `CYC_IO_WRITE);
      end
   endfunction

   function is_io;
      input [1:0] k;
      begin
         is_io = (k == `CYC_IO_READ) || (k == `CYC_IO_WRITE);
      end
   endfunction

   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         sync1_q <= 3'h7;
         sync2_q <= 3'h7;
      end else begin
         sync1_q <= {bus_claim_n_in, urgent_interrupt_n_in, wait_n_in};
         sync2_q <= sync1_q;
      end
   end

   urgent_irq_arb #(
      .NUM_IRQ(NUM_IRQ)
   ) u_arb (
      .urgent_pend_in(urgent_pend_q),
      .irq_pend_in(irq_pend_in),
      .irq_enable_in(irq_enable_in),
      .global_ie_in(global_ie_in),
      .take_urgent_out(take_urgent),
      .take_mask_out(take_mask),
      .mask_sel_out(sel)
   );

   // urgent input is edge-latched so a short pulse is not missed
   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         urgent_prev_q <= 1'b1;
         urgent_pend_q <= 1'b0;
         urgent_take_out <= 1'b0;
         mask_take_out <= 1'b0;
         mask_sel_out <= {NUM_IRQ{1'b0}};
         stop_state_n_out <= 1'b1;
      end else begin
         urgent_prev_q <= urgent_s;
         urgent_take_out <= instr_end_in && take_urgent; // [RULE10]
         mask_take_out <= instr_end_in && take_mask; // [RULE11]
         mask_sel_out <= instr_end_in && take_mask ? sel : {NUM_IRQ{1'b0}};
         // a new falling edge wins over the clear by acceptance
         if (urgent_prev_q && !urgent_s) begin
            urgent_pend_q <= 1'b1;
         end else if (instr_end_in && take_urgent) begin
            urgent_pend_q <= 1'b0;
         end
         if (stop_exec_in) begin
            stop_state_n_out <= 1'b0; // [RULE14]
         end else if (wake_in || (instr_end_in && (take_urgent ||
                      take_mask))) begin
            stop_state_n_out <= 1'b1;
         end
      end
   end

   always @(posedge mclk_in) begin
      if (!resetn_in) begin
         state_q <= ST_IDLE;
         kind_q <= `CYC_MEM_READ;
         fetch_q <= 1'b0;
         req_ready_out <= 1'b0;
         done_out <= 1'b0;
         rdata_out <= {DW{1'b0}};
         granted_out <= 1'b0;
         location_bus_out <= {AW{1'b0}};
         location_bus_oe_out <= 1'b1;
         data_bus_out <= {DW{1'b0}};
         data_bus_oe_out <= 1'b0;
         io_request_n_out <= 1'b1;
         mem_request_n_out <= 1'b1;
         read_strobe_n_out <= 1'b1;
         store_strobe_n_out <= 1'b1;
         opcode_fetch_n_out <= 1'b1;
         ctrl_oe_out <= 1'b1;
         bus_grant_n_out <= 1'b1;
      end else begin
         req_ready_out <= 1'b0;
         done_out <= 1'b0;
         case (state_q)
            ST_IDLE: begin
               if (!claim_s) begin
                  // float everything first, grant on the next edge
                  location_bus_oe_out <= 1'b0; // [RULE13]
                  data_bus_oe_out <= 1'b0;
                  ctrl_oe_out <= 1'b0;
                  state_q <= ST_FLOAT;
               end else if (req_valid_in) begin
                  req_ready_out <= 1'b1;
                  kind_q <= req_kind_in;
                  fetch_q <= req_fetch_in && !is_io(req_kind_in) &&
                             !is_write(req_kind_in);
                  location_bus_out <= req_addr_in;
                  data_bus_out <= req_wdata_in;
                  // data driven only on writes as master
                  data_bus_oe_out <= is_write(req_kind_in); // [RULE15]
                  io_request_n_out <= !is_io(req_kind_in); // [RULE1]
                  mem_request_n_out <= is_io(req_kind_in); // [RULE2]
                  state_q <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               read_strobe_n_out <= is_write(kind_q); // [RULE4]
               store_strobe_n_out <= !is_write(kind_q); // [RULE5]
               opcode_fetch_n_out <= !fetch_q; // [RULE6]
               state_q <= ST_SETTLE;
            end
            ST_SETTLE: begin
               // wait decoded from the new address needs the sync stages
               // to arrive before the first look, else it is missed
               state_q <= ST_STROBE; // [RULE7]
            end
            ST_STROBE: begin
               // wait sampled after the sync stages, so it adds latency
               if (wait_s) begin // [RULE7]
                  rdata_out <= data_bus_in;
                  done_out <= 1'b1;
                  io_request_n_out <= 1'b1;
                  mem_request_n_out <= 1'b1;
                  read_strobe_n_out <= 1'b1;
                  store_strobe_n_out <= 1'b1;
                  opcode_fetch_n_out <= 1'b1;
                  data_bus_oe_out <= 1'b0; // [RULE15]
                  state_q <= ST_IDLE;
               end
            end
            ST_FLOAT: begin
               bus_grant_n_out <= 1'b0; // [RULE13]
               granted_out <= 1'b1;
               state_q <= ST_GRANT;
            end
            ST_GRANT: begin
               // address and requests stay undriven while granted
               if (claim_s) begin // [RULE3]
                  bus_grant_n_out <= 1'b1; // [RULE16]
                  granted_out <= 1'b0;
                  state_q <= ST_RESUME;
               end
            end
            ST_RESUME: begin
               location_bus_oe_out <= 1'b1; // [RULE16]
               ctrl_oe_out <= 1'b1;
               state_q <= ST_IDLE;
            end
            default: begin
               state_q <= ST_IDLE;
            end
         endcase
      end
   end
endmodule

// *** design/ext_bus_map.vh ***
// timing and encoding constants for the external bus controller
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
`define ADDR_WIDTH 24
`define DATA_WIDTH 8
`define CYC_MEM_READ 2'h0
`define CYC_MEM_WRITE 2'h1
`define CYC_IO_READ 2'h2
`define CYC_IO_WRITE 2'h3
`define RESET_MIN_CYCLES 3
`define BUS_CYCLE_MIN_CYCLES 2
`endif

// *** design/urgent_irq_arb.v ***
// interrupt priority picker: urgent source ahead of maskable sources
`timescale 1ns/100ps
module urgent_irq_arb #(
   parameter NUM_IRQ = 8
) (
   input wire urgent_pend_in, // synchronised urgent request pending
   input wire [NUM_IRQ-1:0] irq_pend_in, // maskable requests pending
   input wire [NUM_IRQ-1:0] irq_enable_in, // per-source enables
   input wire global_ie_in, // global interrupt enable
   output reg take_urgent_out, // urgent wins
   output reg take_mask_out, // maskable taken
   output reg [NUM_IRQ-1:0] mask_sel_out // one-hot chosen source
);
   integer i;
   reg found;
   always @* begin
      found = 1'b0;
      take_urgent_out = urgent_pend_in; // [RULE10]
      mask_sel_out = {NUM_IRQ{1'b0}};
      for (i = 0; i < NUM_IRQ; i = i + 1) begin
         if (!found && irq_pend_in[i] && irq_enable_in[i]) begin
            found = 1'b1;
            mask_sel_out[i] = 1'b1;
         end
      end
      // maskable ones only when urgent is not pending
      take_mask_out = found && global_ie_in && !urgent_pend_in; // [RULE11]
      if (urgent_pend_in) begin
         mask_sel_out = {NUM_IRQ{1'b0}};
      end
   end
endmodule

// *** testbench/cpu_external_bus_control_sva.sv ***
// pin-side assertions for the external bus controller
`timescale 1ns/100ps
module ext_bus_sva (
   input wire mclk_in, resetn_in, wait_n_in, stop_exec_in, wake_in,
   input wire io_request_n_out, mem_request_n_out, read_strobe_n_out,
   input wire store_strobe_n_out, opcode_fetch_n_out, ctrl_oe_out,
   input wire location_bus_oe_out, data_bus_oe_out, bus_grant_n_out,
   input wire stop_state_n_out, urgent_take_out, mask_take_out,
   input wire req_ready_out
);
   default clocking @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   sequence one_dir;
      read_strobe_n_out ^ store_strobe_n_out;
   endsequence
   sequence wait_held;
      !wait_n_in [*3];
   endsequence
   sequence any_strobe;
      !(read_strobe_n_out && store_strobe_n_out);
   endsequence
   io_dir_a: assert property ($fell(io_request_n_out) |=> one_dir)
      else $error("io cycle without a single strobe");
   mem_dir_a: assert property (
      $fell(mem_request_n_out) |=> one_dir)
      else $error("memory cycle without a single strobe");
   fetch_qual_a: assert property (
      !opcode_fetch_n_out |-> !mem_request_n_out && io_request_n_out &&
      store_strobe_n_out)
      else $error("fetch marker outside a memory read");
   float_ctrl_a: assert property (
      !bus_grant_n_out |-> !ctrl_oe_out && !location_bus_oe_out &&
      !data_bus_oe_out)
      else $error("pins driven while granted");
   grant_order_a: assert property ($fell(bus_grant_n_out) |->
      !$past(ctrl_oe_out) && !$past(location_bus_oe_out))
      else $error("grant before pins floated");
   data_drive_a: assert property (
      data_bus_oe_out |-> bus_grant_n_out && read_strobe_n_out &&
      !(io_request_n_out && mem_request_n_out))
      else $error("data driven outside a write");
   wait_hold_a: assert property (
      wait_held ##0 any_strobe |=> any_strobe)
      else $error("cycle ended while wait held");
   stop_ind_a: assert property (
      stop_exec_in && !wake_in && !urgent_take_out |=> !stop_state_n_out)
      else $error("stop indicator not low");
   urgent_first_a: assert property (
      urgent_take_out |-> !mask_take_out)
      else $error("maskable taken with urgent");
   release_a: assert property ($rose(bus_grant_n_out) |=>
      ctrl_oe_out && location_bus_oe_out)
      else $error("lines not driven after release");
   no_ready_a: assert property (!bus_grant_n_out |-> !req_ready_out)
      else $error("request taken while granted");
endmodule
bind cpu_external_bus_control ext_bus_sva chk (.*);

// *** testbench/ext_mem_model.sv ***
// slow memory or peripheral on the far side of the bus
`timescale 1ns/100ps
module ext_mem_model (
   input wire clk_in, // system clock
   input wire [23:0] addr_in, // resolved address
   input wire io_n_in, mem_n_in, rd_n_in, wr_n_in, // resolved control
   input wire [7:0] data_in, // resolved data lines
   input wire [3:0] waits_in, // wait cycles per access
   output wire [7:0] data_out, // read data onto the bus
   output wire wait_n_out, // wait request, active low
   output reg [7:0] last_wr_out // last byte written
);
   reg [3:0] cnt_q = 4'h0;
   reg [7:0] hold_q = 8'h00;
   wire act = !io_n_in || !mem_n_in;
   // wait comes from io/mem request decode, so it leads the strobe
   assign wait_n_out = !(act && cnt_q < waits_in);
   // undriven bus flips every cycle so stale data cannot pass
   assign data_out = rd_n_in ? ~hold_q : addr_in[7:0] ^ 8'h5A;
   always @(posedge clk_in) begin
      hold_q <= data_out;
      cnt_q <= act ? cnt_q + (cnt_q < waits_in) : 4'h0;
      if (!wr_n_in) last_wr_out <= data_in;
   end
endmodule

// *** testbench/cpu_external_bus_control_tb.sv ***
// self-checking bench for the external bus controller
`timescale 1ns/100ps
`include "ext_bus_map.vh"
module cpu_external_bus_control_tb;
   reg mclk_in = 0, resetn_in = 0, req_valid_in = 0, req_fetch_in = 0;
   reg instr_end_in = 0, stop_exec_in = 0, wake_in = 0, global_ie_in = 0;
   reg urgent_interrupt_n_in = 1, bus_claim_n_in = 1;
   reg [1:0] req_kind_in = 0;
   reg [23:0] req_addr_in = 0;
   reg [7:0] req_wdata_in = 0, irq_pend_in = 0, irq_enable_in = 0;
   reg [3:0] waits = 0;
   wire req_ready_out, done_out, urgent_take_out, mask_take_out, granted_out;
   wire location_bus_oe_out, data_bus_oe_out, io_request_n_out, ctrl_oe_out;
   wire mem_request_n_out, read_strobe_n_out, store_strobe_n_out, wait_n_in;
   wire opcode_fetch_n_out, bus_grant_n_out, stop_state_n_out;
   wire [7:0] rdata_out, mask_sel_out, data_bus_out, data_bus_in, mdata, last;
   wire [23:0] location_bus_out, location_bus_in;
   integer bad_count = 0, n_checks = 0, i, len, base;
   reg [4:0] seen;
   // released control lines rest at their pull-up level
   wire io_request_n_in = ctrl_oe_out ? io_request_n_out : 1'b1;
   wire mem_request_n_in = ctrl_oe_out ? mem_request_n_out : 1'b1;
   assign data_bus_in = data_bus_oe_out ? data_bus_out : mdata;
   assign location_bus_in = location_bus_oe_out ? location_bus_out :
      24'h3C3C3C;
   cpu_external_bus_control uut (.*);
   ext_mem_model mem (.clk_in(mclk_in), .addr_in(location_bus_in),
      .io_n_in(io_request_n_in), .mem_n_in(mem_request_n_in),
      .rd_n_in(ctrl_oe_out ? read_strobe_n_out : 1'b1),
      .wr_n_in(ctrl_oe_out ? store_strobe_n_out : 1'b1),
      .data_in(data_bus_in), .waits_in(waits), .data_out(mdata),
      .wait_n_out(wait_n_in), .last_wr_out(last));
   initial forever #5 mclk_in = ~mclk_in;
   task check(input [31:0] got, input [31:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d mismatches %0d", n_checks, bad_count);
         if (bad_count == 0 && n_checks > 0) $display("== PASSED ==");
         else $display("== FAILED ==");
         $finish;
      end
   endtask
   task start(input [1:0] k, input f);
      begin
         @(posedge mclk_in);
         req_valid_in <= 1'b1;
         req_kind_in <= k;
         req_fetch_in <= f;
         req_addr_in <= {22'h0, k} + 24'h30;
         req_wdata_in <= 8'hC0 + k;
      end
   endtask
   task run;
      begin
         seen = 5'h1F;
         len = 0;
         do begin
            @(negedge mclk_in);
            len = len + 1;
            seen = seen & {io_request_n_out, mem_request_n_out,
               read_strobe_n_out, store_strobe_n_out, opcode_fetch_n_out};
            @(posedge mclk_in);
            if (req_ready_out === 1'b1) req_valid_in <= 1'b0;
         end while (done_out !== 1'b1 && len < 40);
         if (len == 40) begin
            check(0, 1);
            test_done;
         end
      end
   endtask
   task t_cycle(input [1:0] k, input f);
      begin
         start(k, f);
         run;
         check(seen, {~k[1], k[1], k[0], ~k[0],
            ~(f & ~k[1] & ~k[0])});
         if (k[0]) check(last, 8'hC0 + k);
         else check(rdata_out, 8'h5A ^ (8'h30 + k));
         $display("cycle kind %0d fetch %0d done", k, f);
      end
   endtask
   task t_wait;
      begin
         t_cycle(`CYC_IO_READ, 1'b0);
         base = len;
         waits <= 4'h5;
         t_cycle(`CYC_IO_READ, 1'b0);
         waits <= 4'h0;
         // each cycle of wait held low stretches the transfer by one cycle
         check(len, base + 5);
      end
   endtask
   task t_claim;
      begin
         @(posedge mclk_in);
         bus_claim_n_in <= 1'b0;
         len = 0;
         while (bus_grant_n_out !== 1'b0 && len < 20) begin
            @(negedge mclk_in);
            len = len + 1;
         end
         if (len == 20) begin
            check(0, 1);
            test_done;
         end
         check({granted_out, ctrl_oe_out, location_bus_oe_out,
            data_bus_oe_out}, 4'h8);
         start(`CYC_MEM_WRITE, 1'b0);
         seen = 0;
         repeat (6) @(negedge mclk_in) seen = seen | req_ready_out;
         check(seen, 0);
         @(posedge mclk_in);
         bus_claim_n_in <= 1'b1;
         run;
         check({bus_grant_n_out, last}, 9'h1C1);
         $display("bus hand-over done");
      end
   endtask
   task t_irq(input g, input u, input [9:0] exp);
      begin
         @(posedge mclk_in);
         irq_pend_in <= 8'h0C;
         irq_enable_in <= {8{g}};
         global_ie_in <= g;
         urgent_interrupt_n_in <= !u;
         repeat (4) @(posedge mclk_in);
         instr_end_in <= 1'b1;
         urgent_interrupt_n_in <= 1'b1;
         @(posedge mclk_in);
         instr_end_in <= 1'b0;
         irq_pend_in <= 8'h00;
         seen = 0;
         base = 0;
         repeat (4) begin
            @(negedge mclk_in);
            seen = seen | {urgent_take_out, mask_take_out};
            base = base | mask_sel_out;
         end
         check(seen, exp[9:8]);
         if (!u) check(base, exp[7:0]);
         $display("interrupt case %0d%0d done", g, u);
      end
   endtask
   task t_stop;
      begin
         @(posedge mclk_in);
         stop_exec_in <= 1'b1;
         @(posedge mclk_in);
         stop_exec_in <= 1'b0;
         @(negedge mclk_in);
         check(stop_state_n_out, 0);
         @(posedge mclk_in);
         wake_in <= 1'b1;
         @(posedge mclk_in);
         wake_in <= 1'b0;
         @(negedge mclk_in);
         check(stop_state_n_out, 1);
         $display("stop indicator done");
      end
   endtask
   initial begin
      repeat (3) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(negedge mclk_in);
      check({bus_grant_n_out, stop_state_n_out, ctrl_oe_out,
         data_bus_oe_out}, 4'hE);
      for (i = 0; i < 5; i = i + 1) t_cycle(i[1:0], i == 4);
      t_wait;
      t_claim;
      t_irq(1'b0, 1'b1, 10'h200);
      t_irq(1'b1, 1'b1, 10'h200);
      t_irq(1'b1, 1'b0, 10'h104);
      t_stop;
      test_done;
   end
endmodule
